// >>> include/timer_two_pkg.sv
// Package holding register map, field positions, reset values and timing constants for the capture/reload timer.
package timer_two_pkg;
   // Register offsets on the plain register port.
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_COUNT_LOW = 4'h1;
   localparam logic [3:0] ADDR_COUNT_HIGH = 4'h2;
   localparam logic [3:0] ADDR_CAPTURE_LOW = 4'h3;
   localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h4;
   localparam logic [3:0] ADDR_SERIAL_DATA = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
   localparam logic [3:0] ADDR_SERIAL_STATUS = 4'h8;
   // Control register field positions.
   localparam int BIT_OVERFLOW = 7;
   localparam int BIT_EXT_FLAG = 6;
   localparam int BIT_RX_CLK_SEL = 5;
   localparam int BIT_TX_CLK_SEL = 4;
   localparam int BIT_EXT_ENABLE = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_COUNTER_SEL = 1;
   localparam int BIT_CAP_RELOAD = 0;
   // Interrupt status bit positions.
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_EXT = 1;
   localparam int IRQ_RX_DONE = 2;
   localparam int IRQ_RX_LOST = 3;
   localparam int IRQ_WIDTH = 4;
   // Reset values.
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [IRQ_WIDTH-1:0] IRQ_RESET = 4'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Timing: oscillator periods per machine cycle and per state time.
   localparam int OSC_PER_MACHINE = 12;
   localparam int OSC_PER_STATE = 2;
   localparam logic [15:0] COUNT_ONE = 16'h0001;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
   // Operating modes.
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_RELOAD = 2'b01,
      MODE_CAPTURE = 2'b10,
      MODE_BAUD = 2'b11
   } mode_t;
endpackage : timer_two_pkg

// >>> rtl/fall_sampler.sv
// Once-per-tick sampler that reports a high sample followed by a low sample.
`timescale 1ns/1ps
module fall_sampler (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Sampling tick and pin
   input wire logic sampleTick,
   input wire logic pinIn,
   // Detected edge, one cycle pulse
   output logic fallSeen
);
   logic prevSample_r;
   logic curSample_r;

   // Two samples are held so a level must last a whole tick interval to be seen.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prevSample_r <= 1'b1;
         curSample_r <= 1'b1;
      end else if (sampleTick) begin
         prevSample_r <= curSample_r;
         curSample_r <= pinIn;
      end
   end

   // Edge reported in the tick after the low sample lands.
   assign fallSeen = sampleTick & prevSample_r & ~curSample_r;
endmodule : fall_sampler

// >>> rtl/timer_two_capture_reload.sv
// Sixteen-bit capture/reload timer with baud clock output and serial data holding registers.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// Function
// R1: 16-bit timer or external event counter.
// R2: Mode from run, clock selects, capture select.
// R3: Overflow flag set by hardware, not baud.
// R4: Trigger edge sets external flag, interrupts.
// R5: Receive select routes overflow to receiver.
// R6: Transmit select routes overflow to transmitter.
// R7: Trigger enable gates edges, not in baud.
// R8: Run bit starts and stops counting.
// R9: Counter select: clock/12 or count edges.
// R10: Capture mode copies count on trigger.
// R11: Reload mode reloads on rollover or trigger.
// R12: Either clock select enters baud mode.
// R13: Transmit and receive paths are independent.
// R14: Second receive byte may overrun first.
// R15: Data write to transmit, read from receive.
// R16: Timer ticks once per twelve oscillator periods.
// R17: Count input sampled once per machine cycle.
// R18: Baud mode reloads from capture pair.
// R19: Trigger sampled like count input.
module timer_two_capture_reload #(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // External pins
   input wire logic countInput,
   input wire logic triggerInput,
   // Serial port side
   input wire logic otherTimerOverflow,
   input wire logic rxByteDone,
   input wire logic [7:0] rxByte,
   output logic [7:0] txData,
   output logic txLoad,
   output logic rxSerialClock,
   output logic txSerialClock,
   // Interrupt
   output logic irq
);

   // Register map, one byte per offset.
   // Offset 0 holds the control word.
   // Offsets 1 and 2 hold the count, low and high byte.
   // Offsets 3 and 4 hold the capture pair, also the reload value.
   // Offset 5 takes the transmit byte and returns the receive byte.
   // Offset 6 is the sticky interrupt status, cleared by writing ones.
   // Offset 7 is the interrupt mask, laid out like the status.
   // Offset 8 shows receive-full in bit 0.
   // Other offsets read zero and drop writes.

   // Control bits, top down: overflow flag, trigger flag,
   // receive select, transmit select, trigger enable,
   // run control, counter select, capture/reload select.
   // Software clears either flag by writing a zero to it.

   // Status bits, bottom up: overflow, trigger,
   // byte received, receive overrun.
   // Masked events are still recorded in the status.
   // The interrupt is a level while any unmasked bit is set.

   // Count bytes are written one at a time, unlatched.
   // A running timer may step between the two writes,
   // so software should stop it to load an exact value.

   // Two free dividers on the oscillator clock set the pace.
   // A machine tick every twelve clocks steps the timer.
   // The same tick samples both external pins.
   // A state tick every two clocks steps baud mode.
   // Count and flags change on the edge after the tick.

   // In capture mode a rollover wraps to zero and sets the flag.
   // In reload mode a rollover loads the capture pair.
   // Baud mode reloads the same way but sets no flag.
   // In baud mode the trigger pin is ignored as well.

   // A trigger in capture mode copies the count out.
   // A trigger in reload mode loads the capture pair in.
   // Both set the trigger flag and its status bit.

   // A data write pulses the transmit load next cycle.
   // A received byte sets receive-full and its status.
   // A byte arriving while the last is unread replaces it,
   // so the older byte is lost and overrun is flagged.
   // Reading the data offset clears receive-full.

   // Each serial clock takes this timer's rollover when
   // selected, else the other timer's overflow pulse.
   // Transmit and receive choose apart, so rates may differ.

   // Reset clears every register and starts both pin
   // samplers high, so a pin low through reset counts as one edge.

   localparam logic [3:0] MACHINE_LAST = 4'(timer_two_pkg::OSC_PER_MACHINE - 1);
   localparam logic [3:0] STATE_LAST = 4'(timer_two_pkg::OSC_PER_STATE - 1);
   // Byte lanes of the count and capture words.
   localparam int LOW_MSB = 7;
   localparam int HIGH_LSB = 8;
   localparam int HIGH_MSB = 15;

   // Control word, count and capture pair.
   logic [7:0] control_r;
   logic [COUNT_WIDTH-1:0] count_r;
   logic [COUNT_WIDTH-1:0] count_nxt;
   logic [COUNT_WIDTH-1:0] capture_r;

   // Tick dividers.
   logic [3:0] machineDiv_r;
   logic [3:0] stateDiv_r;

   // Serial holding registers and read data.
   logic [7:0] txData_r;
   logic [7:0] rxHold_r;
   logic rxFull_r;
   logic [7:0] rdData_r;
   logic txLoad_r;

   // Interrupt status and mask.
   logic [timer_two_pkg::IRQ_WIDTH-1:0] irqStatus_r;
   logic [timer_two_pkg::IRQ_WIDTH-1:0] irqMask_r;

   // Control field wires.
   wire runBit = control_r[timer_two_pkg::BIT_RUN];
   wire rxSel = control_r[timer_two_pkg::BIT_RX_CLK_SEL];
   wire txSel = control_r[timer_two_pkg::BIT_TX_CLK_SEL];
   wire extEnable = control_r[timer_two_pkg::BIT_EXT_ENABLE];
   wire counterSel = control_r[timer_two_pkg::BIT_COUNTER_SEL];
   wire capSel = control_r[timer_two_pkg::BIT_CAP_RELOAD];
   wire baudSel = rxSel | txSel; // [R12]

   // Mode decode from the control bits.
   // Off wins over all, then baud mode, then capture select.
   timer_two_pkg::mode_t mode;
   assign mode = !runBit ? timer_two_pkg::MODE_OFF : // [R2] [R8]
                 baudSel ? timer_two_pkg::MODE_BAUD : // [R12]
                 capSel ? timer_two_pkg::MODE_CAPTURE : timer_two_pkg::MODE_RELOAD;

   // Machine cycle and state time tick generators on the oscillator clock.
   // They run free from reset, so the first machine tick
   // follows the eleventh edge; run control does not touch them,
   // so a start may wait up to one tick.
   wire machineTick = (machineDiv_r == MACHINE_LAST); // [R16]
   wire stateTick = (stateDiv_r == STATE_LAST);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         machineDiv_r <= 4'h0;
         stateDiv_r <= 4'h0;
      end else begin
         machineDiv_r <= machineTick ? 4'h0 : machineDiv_r + 4'h1;
         stateDiv_r <= stateTick ? 4'h0 : stateDiv_r + 4'h1;
      end
   end

   // Both pins share the once-per-machine-cycle sampling.
   // A level shorter than a machine cycle may fall between
   // samples, so the source must hold each level that long.
   logic countFall;
   logic trigFall;
   fall_sampler countSampler (
      .ref_clk(ref_clk),
      .rst(rst),
      .sampleTick(machineTick),
      .pinIn(countInput),
      .fallSeen(countFall) // [R17]
   );

   fall_sampler trigSampler (
      .ref_clk(ref_clk),
      .rst(rst),
      .sampleTick(machineTick),
      .pinIn(triggerInput),
      .fallSeen(trigFall) // [R19]
   );

   // Count advance: baud timer mode runs at state rate rather than machine rate.
   // In counter mode pin edges step the count in every running mode.
   wire timerTick = (mode == timer_two_pkg::MODE_BAUD) ? stateTick : machineTick;
   wire countStep = (mode != timer_two_pkg::MODE_OFF) & (counterSel ? countFall : timerTick); // [R1] [R9]
   wire rollover = countStep & (count_r == timer_two_pkg::COUNT_ALL_ONES[COUNT_WIDTH-1:0]);

   // Trigger events are ignored when disabled or while clocking the serial port.
   // A trigger with run clear is dropped, not held for later.
   wire trigEvent = trigFall & extEnable & runBit & ~baudSel; // [R7]
   wire doCapture = trigEvent & (mode == timer_two_pkg::MODE_CAPTURE); // [R10]
   wire doReload = (rollover & (mode != timer_two_pkg::MODE_CAPTURE)) | // [R11] [R18]
                   (trigEvent & (mode == timer_two_pkg::MODE_RELOAD)); // [R11]
   wire overflowSet = rollover & ~baudSel; // [R3]

   // Register write decode.
   // Unmapped offsets match no line here, so their writes are dropped.
   wire wrControl = regWrite & (regAddr == timer_two_pkg::ADDR_CONTROL);
   wire wrCountLow = regWrite & (regAddr == timer_two_pkg::ADDR_COUNT_LOW);
   wire wrCountHigh = regWrite & (regAddr == timer_two_pkg::ADDR_COUNT_HIGH);
   wire wrCapLow = regWrite & (regAddr == timer_two_pkg::ADDR_CAPTURE_LOW);
   wire wrCapHigh = regWrite & (regAddr == timer_two_pkg::ADDR_CAPTURE_HIGH);
   wire wrSerial = regWrite & (regAddr == timer_two_pkg::ADDR_SERIAL_DATA);
   wire wrIrqStatus = regWrite & (regAddr == timer_two_pkg::ADDR_IRQ_STATUS);
   wire wrIrqMask = regWrite & (regAddr == timer_two_pkg::ADDR_IRQ_MASK);
   wire rdSerial = regRead & (regAddr == timer_two_pkg::ADDR_SERIAL_DATA);

   // Next count: software writes win over hardware stepping, reload beats increment.
   // A byte write replaces only its own byte of the stepped value.
   always_comb begin
      count_nxt = count_r;
      if (doReload) begin
         count_nxt = capture_r;
      end else if (countStep) begin
         count_nxt = count_r + COUNT_WIDTH'(timer_two_pkg::COUNT_ONE);
      end
      if (wrCountLow) begin
         count_nxt[LOW_MSB:0] = regWrData;
      end
      if (wrCountHigh) begin
         count_nxt[HIGH_MSB:HIGH_LSB] = regWrData;
      end
   end

   // Count and capture pair.
   // A trigger capture beats a software write in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_r <= timer_two_pkg::COUNT_RESET[COUNT_WIDTH-1:0];
         capture_r <= timer_two_pkg::COUNT_RESET[COUNT_WIDTH-1:0];
      end else begin
         count_r <= count_nxt;
         if (doCapture) begin
            capture_r <= count_r; // [R10]
         end else begin
            if (wrCapLow) begin
               capture_r[LOW_MSB:0] <= regWrData;
            end
            if (wrCapHigh) begin
               capture_r[HIGH_MSB:HIGH_LSB] <= regWrData;
            end
         end
      end
   end

   // Control register; hardware setting of either flag wins over a software clear.
   // Software clears a flag by writing zero to its bit.
   wire extFlagSet = doCapture | (trigEvent & (mode == timer_two_pkg::MODE_RELOAD)); // [R4]
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         control_r <= timer_two_pkg::CONTROL_RESET;
      end else begin
         if (wrControl) begin
            control_r <= regWrData;
         end
         if (overflowSet) begin
            control_r[timer_two_pkg::BIT_OVERFLOW] <= 1'b1; // [R3]
         end
         if (extFlagSet) begin
            control_r[timer_two_pkg::BIT_EXT_FLAG] <= 1'b1; // [R4]
         end
      end
   end

   // Serial data: transmit and receive holding registers are separate and independent.
   // Only software writes one and only the receiver the other.
   wire rxOverrun = rxByteDone & rxFull_r & ~rdSerial; // [R14]
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         txData_r <= timer_two_pkg::DATA_RESET;
         txLoad_r <= 1'b0;
         rxHold_r <= timer_two_pkg::DATA_RESET;
         rxFull_r <= 1'b0;
      end else begin
         txLoad_r <= wrSerial; // [R13]
         if (wrSerial) begin
            txData_r <= regWrData; // [R15]
         end
         // A newer byte replaces an unread one, so the older byte is the one lost.
         if (rxByteDone) begin
            rxHold_r <= rxByte; // [R14]
         end
         if (rxByteDone) begin
            rxFull_r <= 1'b1;
         end else if (rdSerial) begin
            rxFull_r <= 1'b0;
         end
      end
   end

   // Sticky interrupt status, write one to clear; a new event wins over the clear.
   // Each event source feeds one status bit.
   // Masked events stay recorded and raise irq once unmasked.
   logic [timer_two_pkg::IRQ_WIDTH-1:0] irqEvents;
   assign irqEvents[timer_two_pkg::IRQ_OVERFLOW] = overflowSet;
   assign irqEvents[timer_two_pkg::IRQ_EXT] = extFlagSet; // [R4]
   assign irqEvents[timer_two_pkg::IRQ_RX_DONE] = rxByteDone;
   assign irqEvents[timer_two_pkg::IRQ_RX_LOST] = rxOverrun;
   wire [timer_two_pkg::IRQ_WIDTH-1:0] irqClear = wrIrqStatus ? regWrData[timer_two_pkg::IRQ_WIDTH-1:0] : '0;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irqStatus_r <= timer_two_pkg::IRQ_RESET;
         irqMask_r <= timer_two_pkg::IRQ_RESET;
      end else begin
         irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
         if (wrIrqMask) begin
            irqMask_r <= regWrData[timer_two_pkg::IRQ_WIDTH-1:0];
         end
      end
   end
   assign irq = |(irqStatus_r & irqMask_r); // [R4]

   // Read data mux, answered in the cycle after the strobe; unmapped addresses read zero.
   // Read data fall back to zero between answers,
   // so a stale byte never lingers on the port.
   wire [7:0] rdMux =
      (regAddr == timer_two_pkg::ADDR_CONTROL) ? control_r :
      (regAddr == timer_two_pkg::ADDR_COUNT_LOW) ? count_r[LOW_MSB:0] :
      (regAddr == timer_two_pkg::ADDR_COUNT_HIGH) ? count_r[HIGH_MSB:HIGH_LSB] :
      (regAddr == timer_two_pkg::ADDR_CAPTURE_LOW) ? capture_r[LOW_MSB:0] :
      (regAddr == timer_two_pkg::ADDR_CAPTURE_HIGH) ? capture_r[HIGH_MSB:HIGH_LSB] :
      (regAddr == timer_two_pkg::ADDR_SERIAL_DATA) ? rxHold_r : // [R15]
      (regAddr == timer_two_pkg::ADDR_IRQ_STATUS) ? 8'(irqStatus_r) :
      (regAddr == timer_two_pkg::ADDR_IRQ_MASK) ? 8'(irqMask_r) :
      (regAddr == timer_two_pkg::ADDR_SERIAL_STATUS) ? {7'h00, rxFull_r} : 8'h00;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdData_r <= 8'h00;
      end else begin
         rdData_r <= regRead ? rdMux : 8'h00;
      end
   end
   assign regRdData = rdData_r;

   // Serial clock routing: this timer's rollover or the other timer's overflow.
   // The selects switch the source at once, so a pulse
   // may be lost in the cycle that they change.
   assign rxSerialClock = rxSel ? (rollover & runBit) : otherTimerOverflow; // [R5]
   assign txSerialClock = txSel ? (rollover & runBit) : otherTimerOverflow; // [R6]
   assign txData = txData_r;
   assign txLoad = txLoad_r;
endmodule : timer_two_capture_reload

// >>> dv/timer_two_capture_reload_chk.sv
// Port-level assertions for the capture/reload timer, attached by bind.
`timescale 1ns/1ps
module timer_two_capture_reload_chk #(
   parameter int COUNT_WIDTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   // Serial side and interrupt
   input wire logic otherTimerOverflow,
   input wire logic rxByteDone,
   input wire logic [7:0] rxByte,
   input wire logic [7:0] txData,
   input wire logic txLoad,
   input wire logic rxSerialClock,
   input wire logic txSerialClock,
   input wire logic irq
);
   logic [1:0] clkSel_r;
   logic [7:0] rxHold_r;
   wire dataWr = regWrite && regAddr == timer_two_pkg::ADDR_SERIAL_DATA;
   wire dataRd = regRead && regAddr == timer_two_pkg::ADDR_SERIAL_DATA;
   // Shadows stay exact because only software moves the selects and only the receiver the byte.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clkSel_r <= 2'h0;
         rxHold_r <= 8'h00;
      end else begin
         if (regWrite && regAddr == timer_two_pkg::ADDR_CONTROL) clkSel_r <= regWrData[5:4];
         if (rxByteDone) rxHold_r <= rxByte;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_read_idle: assert property (!regRead |=> regRdData == 8'h00)
      else $error("read data outside the answer cycle");
   chk_tx_load: assert property (dataWr |=> txLoad && txData == $past(regWrData))
      else $error("data write did not load the transmitter");
   chk_tx_cause: assert property (txLoad |-> $past(dataWr))
      else $error("transmit load without a data write");
   chk_rx_route: assert property (!clkSel_r[1] |-> rxSerialClock == otherTimerOverflow)
      else $error("receive clock not taken from the other timer");
   chk_tx_route: assert property (!clkSel_r[0] |-> txSerialClock == otherTimerOverflow)
      else $error("transmit clock not taken from the other timer");
   chk_rx_read: assert property (dataRd && !rxByteDone |=> regRdData == $past(rxHold_r))
      else $error("data read did not return the received byte");
   chk_mask_off: assert property (regWrite && regAddr == timer_two_pkg::ADDR_IRQ_MASK &&
      regWrData[3:0] == 4'h0 |=> !irq) else $error("interrupt high with every source masked");
   chk_unmapped_read: assert property (regRead && regAddr > timer_two_pkg::ADDR_SERIAL_STATUS |=> regRdData == 8'h00)
      else $error("unmapped read returned data");
   cov_rx_read: cover property (dataRd ##1 regRdData != 8'h00);
   cov_baud_clk: cover property (clkSel_r[1] && rxSerialClock);
   cov_irq: cover property ($rose(irq));
endmodule : timer_two_capture_reload_chk
bind timer_two_capture_reload timer_two_capture_reload_chk #(.COUNT_WIDTH(COUNT_WIDTH)) chk_i (
   .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .otherTimerOverflow(otherTimerOverflow), .rxByteDone(rxByteDone),
   .rxByte(rxByte), .txData(txData), .txLoad(txLoad), .rxSerialClock(rxSerialClock),
   .txSerialClock(txSerialClock), .irq(irq));

// >>> dv/timer_far_side.sv
// Behavioural far side: count and trigger pins, the other timer and the serial receiver.
`timescale 1ns/1ps
module timer_far_side (
   // Clock
   input wire logic ref_clk,
   // Pins toward the timer, idle high
   output logic countInput = 1'b1,
   output logic triggerInput = 1'b1,
   // Serial side
   output logic otherTimerOverflow = 1'b0,
   output logic rxByteDone = 1'b0,
   output logic [7:0] rxByte = 8'h00
);
   logic [3:0] ovfCnt_r = 4'h0;
   // The neighbouring timer overflows every 16 clocks, a rate unlike this block's baud tests.
   always @(posedge ref_clk) begin
      ovfCnt_r <= ovfCnt_r + 4'h1;
      otherTimerOverflow <= ovfCnt_r == 4'h5;
   end
   // Each level is held beyond one machine cycle so the sampler sees it at least once.
   task automatic fall(input logic trig, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         {triggerInput, countInput} <= {!trig, trig};
         repeat (14) @(posedge ref_clk);
         {triggerInput, countInput} <= 2'b11;
         repeat (14) @(posedge ref_clk);
      end
   endtask : fall
   // One received byte; stale data is inverted afterwards so nothing can lean on it.
   task automatic send(input logic [7:0] b);
      @(posedge ref_clk);
      rxByteDone <= 1'b1;
      rxByte <= b;
      @(posedge ref_clk);
      rxByteDone <= 1'b0;
      rxByte <= ~b;
   endtask : send
endmodule : timer_far_side

// >>> dv/timer_two_capture_reload_bench.sv
// Self-checking bench for the capture/reload timer and its far-side model.
`timescale 1ns/1ps
module timer_two_capture_reload_bench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdData, txData, rxByte, a, b;
   logic countInput, triggerInput, otherTimerOverflow, rxByteDone, txLoad, rxSerialClock, txSerialClock, irq;
   logic [15:0] e;
   int error_cnt = 0;
   int tests_run = 0;
   int seed = 17;
   int n, m;
   // Half period of the 50 ns clock.
   always #25 ref_clk = ~ref_clk;
   timer_two_capture_reload uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .countInput(countInput),
      .triggerInput(triggerInput), .otherTimerOverflow(otherTimerOverflow), .rxByteDone(rxByteDone),
      .rxByte(rxByte), .txData(txData), .txLoad(txLoad), .rxSerialClock(rxSerialClock),
      .txSerialClock(txSerialClock), .irq(irq));
   timer_far_side far (.ref_clk(ref_clk), .countInput(countInput), .triggerInput(triggerInput),
      .otherTimerOverflow(otherTimerOverflow), .rxByteDone(rxByteDone), .rxByte(rxByte));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Register offsets: 0 control, 1/2 count, 3/4 capture, 5 data, 6 status, 7 mask, 8 serial status.
   task automatic wr(input logic [3:0] ad, input logic [7:0] wd);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= ad;
      regWrData <= wd;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rchk(input logic [3:0] ad, input logic [7:0] exp);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= ad;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk(16'(regRdData), 16'(exp));
   endtask : rchk
   // Serial clock pulses last one cycle, so each cycle is looked at once after it settles.
   task automatic pulses(input int span, output int r, output int t);
      r = 0;
      t = 0;
      repeat (span) begin
         @(posedge ref_clk);
         #1;
         r += int'(rxSerialClock === 1'b1);
         t += int'(txSerialClock === 1'b1);
      end
   endtask : pulses
   function automatic logic [15:0] stepped(input logic [7:0] lo, input logic [7:0] hi, input int k);
      return {hi, lo} + 16'(k);
   endfunction : stepped
   task automatic close_out;
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   // Watchdog: the sequence needs about six hundred cycles, so this span means a hang.
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(4'h0, 8'h00);
      wr(4'h7, 8'h0f);
      // Reload mode on machine cycles: two steps from 0xfffe roll over to the preset pair.
      wr(4'h3, 8'h34);
      wr(4'h4, 8'h12);
      wr(4'h1, 8'hfe);
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h04);
      n = 0;
      while (irq !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(16'(n >= 12 && n <= 28), 16'h1);
      rchk(4'h0, 8'h84);
      wr(4'h0, 8'h00);
      repeat (30) @(posedge ref_clk);
      rchk(4'h1, 8'h34);
      rchk(4'h2, 8'h12);
      // Event counting in capture mode from a random start.
      wr(4'h6, 8'h0f);
      a = 8'($random(seed));
      wr(4'h1, a);
      wr(4'h2, 8'h00);
      wr(4'h0, 8'h0f);
      far.fall(1'b0, 5);
      far.fall(1'b1, 1);
      e = stepped(a, 8'h00, 5);
      rchk(4'h3, e[7:0]);
      rchk(4'h4, e[15:8]);
      rchk(4'h0, 8'h4f);
      rchk(4'h6, 8'h02);
      // Trigger ignored with the enable clear, then a trigger reload.
      wr(4'h6, 8'h0f);
      wr(4'h2, 8'h03);
      wr(4'h0, 8'h06);
      far.fall(1'b1, 1);
      rchk(4'h6, 8'h00);
      rchk(4'h2, 8'h03);
      wr(4'h0, 8'h0e);
      far.fall(1'b1, 1);
      rchk(4'h1, e[7:0]);
      rchk(4'h2, e[15:8]);
      rchk(4'h0, 8'h4e);
      // Baud mode steps every 2 clocks; from 0xfffc it rolls over every 8 clocks.
      wr(4'h6, 8'h0f);
      wr(4'h3, 8'hfc);
      wr(4'h4, 8'hff);
      wr(4'h1, 8'hfc);
      wr(4'h2, 8'hff);
      wr(4'h0, 8'h3c);
      pulses(80, n, m);
      chk(16'(n >= 9 && n <= 11 && m == n), 16'h1);
      far.fall(1'b1, 1);
      rchk(4'h0, 8'h3c);
      rchk(4'h6, 8'h00);
      wr(4'h0, 8'h14);
      pulses(80, n, m);
      chk(16'(n <= 6 && m >= 9 && m <= 11), 16'h1);
      wr(4'h0, 8'h00);
      // Transmit load, then a receive overrun that keeps the newer byte.
      a = 8'($random(seed));
      b = 8'($random(seed));
      wr(4'h6, 8'h0f);
      wr(4'h5, a);
      chk(16'(txData), 16'(a));
      far.send(b);
      rchk(4'h8, 8'h01);
      far.send(a);
      rchk(4'h5, a);
      rchk(4'h6, 8'h0c);
      rchk(4'h8, 8'h00);
      chk(16'(irq), 16'h1);
      wr(4'h7, 8'h00);
      chk(16'(irq), 16'h0);
      wr(4'h7, 8'h0f);
      wr(4'h6, 8'h0c);
      chk(16'(irq), 16'h0);
      rchk(4'hc, 8'h00);
      close_out();
   end
endmodule : timer_two_capture_reload_bench
